// >>> iab_pkg.sv
package iab_pkg;

    // register byte addresses
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_CMD  = 5'h04;
    localparam logic [4:0] ADDR_STAT = 5'h08;
    localparam logic [4:0] ADDR_DATA = 5'h0C;
    localparam logic [4:0] ADDR_XCNT = 5'h10;

    // control register fields
    localparam int CTRL_IE   = 0;
    localparam int CTRL_XEN  = 1;
    localparam int CTRL_ACK_JUDGE_ENABLE = 3;
    localparam int CTRL_TRS  = 4;
    localparam int CTRL_MST  = 5;

    // command register fields
    localparam int CMD_SCP   = 0;
    localparam int CMD_IFACE_INTERRUPT_FLAG  = 1;
    localparam int CMD_BUS_BUSY_FLAG  = 2;

    // status register fields
    localparam int STAT_TRANSMIT_EMPTY_FLAG = 0;
    localparam int STAT_TRANSFER_REQUEST_FLAG = 1;
    localparam int STAT_RECEIVED_ACK_STATUS = 2;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] XCNT_RST = 8'h00;

    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCL_HALF_NS   = 5000;
    localparam int SCL_HALF_CYC  = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // sequencer phases of start and stop
    localparam logic [1:0] PH_FIRST = 2'h0;
    localparam logic [1:0] PH_LAST  = 2'h2;

    typedef enum logic [2:0] {
        IAB_IDLE  = 3'h0,
        IAB_START = 3'h1,
        IAB_DLOW  = 3'h3,
        IAB_DHIGH = 3'h2,
        IAB_ALOW  = 3'h6,
        IAB_AHIGH = 3'h7,
        IAB_HOLD  = 3'h5,
        IAB_STOP  = 3'h4
    } iab_state_t;

endpackage

// >>> iab_line_if.sv
interface iab_line_if;
    logic scl_s;
    logic sda_s;
    logic start_p;
    logic stop_p;

    modport det (
        output scl_s,
        output sda_s,
        output start_p,
        output stop_p
    );

    modport core (
        input  scl_s,
        input  sda_s,
        input  start_p,
        input  stop_p
    );
endinterface

// >>> iab_cond_det.sv
module iab_cond_det (
    // clock and reset
    input  wire logic   clk_sys_i,
    input  wire logic   sys_rst_i,
    // bus lines
    input  wire logic   scl_i,
    input  wire logic   sda_i,
    // to core
    iab_line_if.det     line
);

    logic scl_m_q;
    logic scl_s_q;
    logic scl_p_q;
    logic sda_m_q;
    logic sda_s_q;
    logic sda_p_q;

    // idle bus is high, so the chain resets high and shows no condition
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    assign line.scl_s   = scl_s_q;
    assign line.sda_s   = sda_s_q;
    assign line.start_p = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign line.stop_p  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

endmodule

// >>> iab_core.sv
// Functional notes
// - judgement off: received acknowledge ignored, transfer keeps going
// - judgement off: received-acknowledge status always reads 0
// - judgement on and acknowledge 1: continuous transfer stops
// - judgement off: byte end sets transmit-empty, interrupt and transfer-request flags
// - judgement on: ack 0 sets all three flags, ack 1 only interrupt flag
// - transfer-request flag at 1 requests the transfer controller
// - controller transfers clear the three flags, so no interrupt while streaming
// - ack 1 with judgement on: no controller request, interrupt if enabled
// - software reads bus-busy to see whether the bus is occupied
// - SDA falling while SCL high sets bus-busy
// - SDA rising while SCL high clears bus-busy
// - bus-busy writes ignored in slave mode
// - master: write busy 1 with control 0 issues repeated start, or a start from idle only with transmit mode set
// - judgement select is control bit 3, read/write, reset 0
//
// Design decisions made here: the register offsets and strobed register access.
module iab_core #(
    parameter int HALF_CYC = iab_pkg::SCL_HALF_CYC
) (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    // register port
    input  wire logic [4:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // transfer controller
    output logic            xfer_req_o,
    input  wire logic       xfer_wr_i,
    input  wire logic [7:0] xfer_data_i,
    // interrupt
    output logic            irq_o,
    // bus pins, open drain
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_n_o,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n_o
);

    iab_line_if line ();
    iab_cond_det u_det (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .line      (line)
    );

    iab_pkg::iab_state_t state_q;
    iab_pkg::iab_state_t state_d;
    logic [7:0]          ctrl_q;
    logic [7:0]          data_q;
    logic [7:0]          cnt_q;
    logic [7:0]          rdata_q;
    logic [7:0]          shift_q;
    logic [7:0]          shift_d;
    logic [2:0]          bit_q;
    logic [2:0]          bit_d;
    logic [1:0]          phase_q;
    logic [1:0]          phase_d;
    logic [15:0]         div_q;
    logic                transmit_empty_flag_q;
    logic                transfer_request_flag_q;
    logic                iface_interrupt_flag_q;
    logic                received_ack_status_q;
    logic                bus_busy_flag_q;
    logic                start_pend_q;
    logic                stop_pend_q;
    logic                scl_pull_q;
    logic                sda_pull_q;
    // register decode
    wire       wr_ctrl_w = reg_wr_i & (reg_addr_i == iab_pkg::ADDR_CTRL);
    wire       wr_cmd_w  = reg_wr_i & (reg_addr_i == iab_pkg::ADDR_CMD);
    wire       wr_stat_w = reg_wr_i & (reg_addr_i == iab_pkg::ADDR_STAT);
    wire       wr_data_w = reg_wr_i & (reg_addr_i == iab_pkg::ADDR_DATA);
    wire       wr_xcnt_w = reg_wr_i & (reg_addr_i == iab_pkg::ADDR_XCNT);
    wire       ack_judge_enable_w    = ctrl_q[iab_pkg::CTRL_ACK_JUDGE_ENABLE];
    wire       mst_w     = ctrl_q[iab_pkg::CTRL_MST];
    wire       trs_w     = ctrl_q[iab_pkg::CTRL_TRS];
    wire       xen_w     = ctrl_q[iab_pkg::CTRL_XEN];
    wire       ie_w      = ctrl_q[iab_pkg::CTRL_IE];
    wire       received_ack_status_rd_w = received_ack_status_q & ack_judge_enable_w;

    // commands only exist in master mode; slave writes to busy do nothing
    wire       cmd_ok_w    = wr_cmd_w & mst_w & ~reg_wdata_i[iab_pkg::CMD_SCP];
    wire       cmd_start_w = cmd_ok_w & reg_wdata_i[iab_pkg::CMD_BUS_BUSY_FLAG];
    wire       cmd_stop_w  = cmd_ok_w & ~reg_wdata_i[iab_pkg::CMD_BUS_BUSY_FLAG];

    wire [7:0] rd_ctrl_w = ctrl_q;
    wire [7:0] rd_cmd_w  = {5'h00, bus_busy_flag_q, iface_interrupt_flag_q, 1'b1};
    wire [7:0] rd_stat_w = {5'h00, received_ack_status_rd_w, transfer_request_flag_q, transmit_empty_flag_q};
    wire [7:0] rd_mux_w  = (reg_addr_i == iab_pkg::ADDR_CTRL) ? rd_ctrl_w :
                           (reg_addr_i == iab_pkg::ADDR_CMD)  ? rd_cmd_w  :
                           (reg_addr_i == iab_pkg::ADDR_STAT) ? rd_stat_w :
                           (reg_addr_i == iab_pkg::ADDR_DATA) ? data_q    :
                           (reg_addr_i == iab_pkg::ADDR_XCNT) ? cnt_q     : 8'h00;

    // sequencer timing and events
    wire       run_w        = (state_q != iab_pkg::IAB_IDLE) & (state_q != iab_pkg::IAB_HOLD);
    wire       tick_w       = (div_q == 16'(HALF_CYC - 1));
    wire       start_done_w = (state_q == iab_pkg::IAB_START) & tick_w
                              & (phase_q == iab_pkg::PH_LAST);
    wire       byte_done_w  = (state_q == iab_pkg::IAB_AHIGH) & tick_w;
    wire       nack_w       = line.sda_s;
    wire       good_w       = byte_done_w & (~ack_judge_enable_w | ~nack_w);
    wire       set_flags_w  = start_done_w | good_w;
    wire       set_iface_interrupt_flag_w   = start_done_w | byte_done_w;
    wire       ack_stop_w   = ack_judge_enable_w & received_ack_status_q;
    wire       cnt_nz_w     = (cnt_q != 8'h00);
    wire       start_take_w = start_pend_q & ~stop_pend_q
                              & (((state_q == iab_pkg::IAB_IDLE) & trs_w)
                              | (state_q == iab_pkg::IAB_HOLD));
    wire       stop_take_w  = stop_pend_q & ((state_q == iab_pkg::IAB_IDLE)
                              | (state_q == iab_pkg::IAB_HOLD));
    // flag updates; a set in the same cycle as a clear wins
    wire clr_transmit_empty_flag_w = wr_data_w | xfer_wr_i;
    wire clr_transfer_request_flag_w = wr_data_w | xfer_wr_i | (wr_stat_w & ~reg_wdata_i[iab_pkg::STAT_TRANSFER_REQUEST_FLAG]);
    wire clr_iface_interrupt_flag_w = xfer_wr_i | (wr_cmd_w & ~reg_wdata_i[iab_pkg::CMD_IFACE_INTERRUPT_FLAG]);
    wire transmit_empty_flag_d     = set_flags_w | (transmit_empty_flag_q & ~clr_transmit_empty_flag_w);
    wire transfer_request_flag_d     = set_flags_w | (transfer_request_flag_q & ~clr_transfer_request_flag_w);
    wire iface_interrupt_flag_d     = set_iface_interrupt_flag_w | (iface_interrupt_flag_q & ~clr_iface_interrupt_flag_w);
    wire received_ack_status_d     = byte_done_w ? (ack_judge_enable_w & nack_w) : (received_ack_status_q & ~cmd_start_w);
    wire bus_busy_flag_d     = line.start_p | (bus_busy_flag_q & ~line.stop_p);
    wire spend_d    = mst_w & (cmd_start_w | (start_pend_q & ~start_take_w));
    wire ppend_d    = mst_w & (cmd_stop_w | (stop_pend_q & ~stop_take_w));
    wire [7:0] cnt_d  = wr_xcnt_w ? reg_wdata_i :
                        (xfer_wr_i & cnt_nz_w) ? (cnt_q - 8'h01) : cnt_q;
    wire [7:0] data_d = xfer_wr_i ? xfer_data_i : (wr_data_w ? reg_wdata_i : data_q);
    wire [15:0] div_d = (~run_w | tick_w) ? 16'h0000 : (div_q + 16'h0001);

    // open-drain pulls; data moves as SCL falls, so synced sensing sees no condition
    wire in_start_w = (state_q == iab_pkg::IAB_START);
    wire in_stop_w  = (state_q == iab_pkg::IAB_STOP);
    wire in_data_w  = (state_q == iab_pkg::IAB_DLOW) | (state_q == iab_pkg::IAB_DHIGH);
    wire scl_pull_d = (state_q == iab_pkg::IAB_DLOW) | (state_q == iab_pkg::IAB_ALOW)
                      | (state_q == iab_pkg::IAB_HOLD)
                      | ((in_start_w | in_stop_w) & (phase_q == iab_pkg::PH_FIRST));
    wire sda_pull_d = (in_data_w & ~shift_q[7])
                      | (in_start_w & (phase_q == iab_pkg::PH_LAST))
                      | (in_stop_w & (phase_q != iab_pkg::PH_LAST));

    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        bit_d   = bit_q;
        shift_d = shift_q;
        case (state_q)
            iab_pkg::IAB_IDLE: begin
                if (start_take_w) begin
                    state_d = iab_pkg::IAB_START;
                    phase_d = iab_pkg::PH_FIRST;
                end
            end
            iab_pkg::IAB_START: begin
                if (tick_w) begin
                    if (phase_q == iab_pkg::PH_LAST) begin
                        state_d = iab_pkg::IAB_HOLD;
                    end else begin
                        phase_d = phase_q + 2'h1;
                    end
                end
            end
            iab_pkg::IAB_HOLD: begin
                if (stop_pend_q) begin
                    state_d = iab_pkg::IAB_STOP;
                    phase_d = iab_pkg::PH_FIRST;
                end else if (start_pend_q) begin
                    state_d = iab_pkg::IAB_START;
                    phase_d = iab_pkg::PH_FIRST;
                end else if (~transmit_empty_flag_q & ~ack_stop_w) begin
                    state_d = iab_pkg::IAB_DLOW;
                    shift_d = data_q;
                    bit_d   = 3'h7;
                end
            end
            iab_pkg::IAB_DLOW: begin
                if (tick_w) begin
                    state_d = iab_pkg::IAB_DHIGH;
                end
            end
            iab_pkg::IAB_DHIGH: begin
                if (tick_w) begin
                    if (bit_q == 3'h0) begin
                        state_d = iab_pkg::IAB_ALOW;
                    end else begin
                        state_d = iab_pkg::IAB_DLOW;
                        shift_d = {shift_q[6:0], 1'b0};
                        bit_d   = bit_q - 3'h1;
                    end
                end
            end
            iab_pkg::IAB_ALOW: begin
                if (tick_w) begin
                    state_d = iab_pkg::IAB_AHIGH;
                end
            end
            iab_pkg::IAB_AHIGH: begin
                if (tick_w) begin
                    state_d = iab_pkg::IAB_HOLD;
                end
            end
            iab_pkg::IAB_STOP: begin
                if (tick_w) begin
                    if (phase_q == iab_pkg::PH_LAST) begin
                        state_d = iab_pkg::IAB_IDLE;
                    end else begin
                        phase_d = phase_q + 2'h1;
                    end
                end
            end
            default: begin
                state_d = iab_pkg::IAB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= iab_pkg::IAB_IDLE;
            phase_q <= iab_pkg::PH_FIRST;
            bit_q   <= 3'h0;
            shift_q <= 8'h00;
            div_q   <= 16'h0000;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
            bit_q   <= bit_d;
            shift_q <= shift_d;
            div_q   <= div_d;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_q <= iab_pkg::CTRL_RST;
            data_q <= iab_pkg::DATA_RST;
            cnt_q  <= iab_pkg::XCNT_RST;
        end else begin
            ctrl_q <= wr_ctrl_w ? reg_wdata_i : ctrl_q;
            data_q <= data_d;
            cnt_q  <= cnt_d;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            transmit_empty_flag_q       <= 1'b0;
            transfer_request_flag_q       <= 1'b0;
            iface_interrupt_flag_q       <= 1'b0;
            received_ack_status_q       <= 1'b0;
            bus_busy_flag_q       <= 1'b0;
            start_pend_q <= 1'b0;
            stop_pend_q  <= 1'b0;
        end else begin
            transmit_empty_flag_q       <= transmit_empty_flag_d;
            transfer_request_flag_q       <= transfer_request_flag_d;
            iface_interrupt_flag_q       <= iface_interrupt_flag_d;
            received_ack_status_q       <= received_ack_status_d;
            bus_busy_flag_q       <= bus_busy_flag_d;
            start_pend_q <= spend_d;
            stop_pend_q  <= ppend_d;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scl_pull_q <= 1'b0;
            sda_pull_q <= 1'b0;
            rdata_q    <= 8'h00;
        end else begin
            scl_pull_q <= scl_pull_d;
            sda_pull_q <= sda_pull_d;
            rdata_q    <= reg_rd_i ? rd_mux_w : 8'h00;
        end
    end

    // the controller is idle once its count runs out, so the last byte interrupts
    assign xfer_req_o  = transfer_request_flag_q & xen_w & cnt_nz_w;
    assign irq_o       = iface_interrupt_flag_q & ie_w & ~xfer_req_o;
    assign reg_rdata_o = rdata_q;
    assign scl_o       = 1'b0;
    assign sda_o       = 1'b0;
    assign scl_oe_n_o  = ~scl_pull_q;
    assign sda_oe_n_o  = ~sda_pull_q;

    received_ack_status_zero_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        reg_rd_i && reg_addr_i == iab_pkg::ADDR_STAT && !ack_judge_enable_w
        |=> !reg_rdata_o[iab_pkg::STAT_RECEIVED_ACK_STATUS])
        else $error("ack status visible with judgement off");
    nack_halt_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        state_q == iab_pkg::IAB_HOLD && ack_stop_w && !start_pend_q && !stop_pend_q
        |=> state_q == iab_pkg::IAB_HOLD)
        else $error("transfer continued after refused byte");
    flags_off_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        byte_done_w && !ack_judge_enable_w |=> transmit_empty_flag_q && transfer_request_flag_q && iface_interrupt_flag_q)
        else $error("flags missing after byte with judgement off");
    nack_flags_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        byte_done_w && ack_judge_enable_w && nack_w && !transmit_empty_flag_q && !transfer_request_flag_q
        |=> iface_interrupt_flag_q && received_ack_status_q && !transmit_empty_flag_q && !transfer_request_flag_q)
        else $error("wrong flags after refused byte");
    xfer_req_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        set_flags_w && xen_w && cnt_nz_w && !xfer_wr_i && !wr_xcnt_w && !wr_ctrl_w |=> xfer_req_o)
        else $error("controller not requested");
    xfer_clear_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        xfer_wr_i && !set_flags_w && !set_iface_interrupt_flag_w |=> !transmit_empty_flag_q && !transfer_request_flag_q && !iface_interrupt_flag_q)
        else $error("controller write did not clear flags");
    nack_noreq_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        byte_done_w && ack_judge_enable_w && nack_w && !transfer_request_flag_q && !xfer_wr_i
        |=> !xfer_req_o && (irq_o == ie_w))
        else $error("refused byte handled wrongly");
    busy_read_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        reg_rd_i && reg_addr_i == iab_pkg::ADDR_CMD
        |=> reg_rdata_o[iab_pkg::CMD_BUS_BUSY_FLAG] == $past(bus_busy_flag_q))
        else $error("bus busy read mismatch");
    start_busy_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        line.start_p |=> bus_busy_flag_q)
        else $error("start did not set busy");
    stop_free_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        line.stop_p |=> !bus_busy_flag_q)
        else $error("stop did not clear busy");
    slave_cmd_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        wr_cmd_w && !mst_w |=> !start_pend_q && !stop_pend_q)
        else $error("command taken in slave mode");
    start_issue_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        state_q == iab_pkg::IAB_IDLE && start_take_w
        |-> ##[1:800] (!sda_oe_n_o && scl_oe_n_o))
        else $error("start condition not driven");
    stop_issue_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        state_q == iab_pkg::IAB_HOLD && stop_pend_q |=> state_q == iab_pkg::IAB_STOP)
        else $error("stop not started");

endmodule

// >>> iab_slave_model.sv
module iab_slave_model (
    // bus lines
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    // behaviour
    input  wire logic       ack_val_i,
    // results
    output logic            sda_pull_o,
    output logic      [7:0] rx_byte_o,
    output logic      [7:0] byte_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int rise_cnt = 0;
    initial begin
        sda_pull_o = 1'b0;
        rx_byte_o  = 8'h00;
        byte_cnt_o = 8'h00;
    end
    // a start restarts bit counting, so stray edges before it do no harm;
    // the short wait lets SCL settle when both lines move in one time step
    always @(negedge sda_i) begin
        #1;
        if (scl_i && !sda_i) begin
            rise_cnt = 0;
        end
    end
    always @(posedge scl_i) begin
        rise_cnt = rise_cnt + 1;
        if (rise_cnt <= 8) begin
            rx_byte_o = {rx_byte_o[6:0], sda_i};
        end
        if (rise_cnt == 9) begin
            byte_cnt_o = byte_cnt_o + 8'h01;
        end
    end
    // ack is held for the whole ninth clock, released on its falling edge
    always @(negedge scl_i) begin
        sda_pull_o = (rise_cnt == 8) && !ack_val_i;
        if (rise_cnt == 9) begin
            rise_cnt = 0;
        end
    end
endmodule

// >>> i2c_ack_judge_bus_busy_test.sv
module i2c_ack_judge_bus_busy_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic [4:0] reg_addr  = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic       xfer_wr   = 1'b0;
    logic [7:0] xfer_data = 8'h00;
    logic       ack_val   = 1'b0;
    logic       ext_sda   = 1'b0;
    logic [7:0] rdata, rx_byte, byte_cnt, n;
    logic       xfer_req_o, irq_o, scl_oe_n, sda_oe_n, sl_pull;
    logic       scl_dat, sda_dat;
    int         err_count = 0;
    int         total_checks = 0;
    // open drain lines with pull-ups
    wire scl_w = scl_oe_n;
    wire sda_w = sda_oe_n & ~sl_pull & ~ext_sda;

    iab_core #(.HALF_CYC(4)) uut (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
        .xfer_req_o(xfer_req_o), .xfer_wr_i(xfer_wr), .xfer_data_i(xfer_data),
        .irq_o(irq_o),
        .scl_i(scl_w), .scl_o(scl_dat), .scl_oe_n_o(scl_oe_n),
        .sda_i(sda_w), .sda_o(sda_dat), .sda_oe_n_o(sda_oe_n)
    );
    iab_slave_model slave (
        .scl_i(scl_w), .sda_i(sda_w), .ack_val_i(ack_val),
        .sda_pull_o(sl_pull), .rx_byte_o(rx_byte), .byte_cnt_o(byte_cnt)
    );

    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr    <= 1'b0;
        // one idle edge, so a following write never re-raises the strobe in this step
        @(posedge clk_sys_i);
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd   <= 1'b0;
        #1 d = rdata;
        @(posedge clk_sys_i);
    endtask

    task automatic rdc(input logic [4:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        rd(a, d);
        chk(nm, d, e);
    endtask

    task automatic sig(input string nm, input logic e);
        #1 chk(nm, {7'h00, (nm == "irq") ? irq_o : (nm == "req") ? xfer_req_o
                     : (nm == "scl") ? scl_w : sda_w}, {7'h00, e});
        @(posedge clk_sys_i);
    endtask

    // bounded wait on a register field
    task automatic poll(input logic [4:0] a, input logic [7:0] m, input logic [7:0] v,
                        input string nm);
        logic [7:0] d;
        int         k;
        k = 0;
        do begin
            rd(a, d);
            k++;
        end while (((d & m) !== v) && k < 300);
        chk(nm, d & m, v);
    endtask

    // whole run is well under a thousand cycles; this leaves ample margin
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        err_count++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        rdc(iab_pkg::ADDR_CTRL, 8'h00, "ctrl_rst");
        wr(iab_pkg::ADDR_CTRL, 8'h08);
        rdc(iab_pkg::ADDR_CTRL, 8'h08, "ctrl_ack_judge_enable");
        rdc(iab_pkg::ADDR_CMD, 8'h01, "cmd_rst");
        wr(iab_pkg::ADDR_CTRL, 8'h00);
        $display("test reset done");
        // slave mode: a foreign master starts and stops
        ext_sda <= 1'b1;
        poll(iab_pkg::ADDR_CMD, 8'h04, 8'h04, "slv_busy");
        wr(iab_pkg::ADDR_CMD, 8'h00);
        rdc(iab_pkg::ADDR_CMD, 8'h05, "slv_wr_busy");
        ext_sda <= 1'b0;
        poll(iab_pkg::ADDR_CMD, 8'h04, 8'h00, "slv_free");
        $display("test slave busy done");
        // master transmit, judgement off, slave answers 1
        ack_val <= 1'b1;
        wr(iab_pkg::ADDR_CTRL, 8'h30);
        wr(iab_pkg::ADDR_CMD, 8'h04);
        poll(iab_pkg::ADDR_STAT, 8'h01, 8'h01, "start_transmit_empty_flag");
        rdc(iab_pkg::ADDR_CMD, 8'h07, "start_busy");
        for (int i = 0; i < 2; i++) begin
            wr(iab_pkg::ADDR_CMD, 8'h05);
            wr(iab_pkg::ADDR_DATA, 8'hA5 ^ {8{i[0]}});
            poll(iab_pkg::ADDR_STAT, 8'h01, 8'h01, "noj_transmit_empty_flag");
            rdc(iab_pkg::ADDR_STAT, 8'h03, "noj_stat");
            rdc(iab_pkg::ADDR_CMD, 8'h07, "noj_iface_interrupt_flag");
            chk("rx_byte", rx_byte, 8'hA5 ^ {8{i[0]}});
        end
        $display("test judgement off done");
        // transfer controller streams the last byte
        ack_val <= 1'b0;
        wr(iab_pkg::ADDR_XCNT, 8'h01);
        wr(iab_pkg::ADDR_CTRL, 8'h3B);
        sig("req", 1'b1);
        sig("irq", 1'b0);
        xfer_wr   <= 1'b1;
        xfer_data <= 8'hC3;
        @(posedge clk_sys_i);
        xfer_wr   <= 1'b0;
        rdc(iab_pkg::ADDR_STAT, 8'h00, "ctl_clear");
        poll(iab_pkg::ADDR_STAT, 8'h01, 8'h01, "ctl_transmit_empty_flag");
        rdc(iab_pkg::ADDR_STAT, 8'h03, "ctl_stat");
        sig("req", 1'b0);
        sig("irq", 1'b1);
        chk("rx_byte", rx_byte, 8'hC3);
        $display("test controller done");
        // judgement on, slave answers 1
        ack_val <= 1'b1;
        wr(iab_pkg::ADDR_XCNT, 8'h02);
        wr(iab_pkg::ADDR_CMD, 8'h05);
        wr(iab_pkg::ADDR_DATA, 8'h3C);
        poll(iab_pkg::ADDR_CMD, 8'h02, 8'h02, "j1_iface_interrupt_flag");
        rdc(iab_pkg::ADDR_STAT, 8'h04, "j1_stat");
        sig("req", 1'b0);
        sig("irq", 1'b1);
        n = byte_cnt;
        wr(iab_pkg::ADDR_DATA, 8'h55);
        repeat (200) @(posedge clk_sys_i);
        chk("j1_halt", byte_cnt, n);
        wr(iab_pkg::ADDR_CMD, 8'h04);
        poll(iab_pkg::ADDR_STAT, 8'h01, 8'h01, "rs_transmit_empty_flag");
        rdc(iab_pkg::ADDR_STAT, 8'h03, "rs_stat");
        wr(iab_pkg::ADDR_CMD, 8'h00);
        poll(iab_pkg::ADDR_CMD, 8'h04, 8'h00, "stop_busy");
        sig("scl", 1'b1);
        sig("sda", 1'b1);
        chk("pin_data", {6'h00, scl_dat, sda_dat}, 8'h00);
        $display("test judgement on done");
        close_out();
    end
endmodule
